// File: test/epr_reset_switch.sv
`timescale 1ns/1ps
`default_nettype none
// external reset switch with a pull-up on the pin
module epr_reset_switch (
    // press request from the bench
    input wire logic press_i,
    // device pad signals
    input wire logic pad_o_i,
    input wire logic pad_oe_i,
    // resolved pin level
    output logic pin_o
);
    // pull-up sets the level when nobody pulls the pin low
    assign pin_o = pad_oe_i ? pad_o_i : !press_i;
endmodule : epr_reset_switch
`default_nettype wire

// File: test/external_and_power_on_reset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module external_and_power_on_reset_bench;
    logic clk_i, arst_n_i = 1'b0, press = 1'b0, cfg = 1'b1;
    logic wd = 1'b0, fwr = 1'b0, fwd = 1'b0;
    wire logic pin, pad_o, pad_oe, flag, pdata, srst_n, porp;
    int num_errors = 0;
    int num_checks = 0;
    // far side: reset switch
    epr_reset_switch u_sw (.press_i(press), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .pin_o(pin));
    epr_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .external_reset_pin_i(pin),
        .external_reset_pin_o(pad_o), .external_reset_pin_oe_o(pad_oe),
        .ext_reset_pin_enable_cfg_i(cfg), .watchdog_timer_rst_i(wd),
        .por_flag_wr_i(fwr), .por_flag_wdata_i(fwd), .por_flag_o(flag),
        .pin_data_o(pdata), .sys_rst_n_o(srst_n), .por_pulse_o(porp));
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // one-bit compare
    task chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t ns output bit differs", $time);
        end
    endtask : chk
    // advance n edges, then let updates land
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    // bounded wait for the combined reset to lift
    task wait_rel(input int n);
        for (int i = 0; i < n && srst_n !== 1'b1; i++) step(1);
        chk(srst_n, 1'b1);
    endtask : wait_rel
    // power-on with flag and pulse checks
    task t_por;
        @(posedge clk_i) arst_n_i <= 1'b0;
        step(4);
        chk(flag, 1'b0);
        chk(porp, 1'b1);
        @(posedge clk_i) arst_n_i <= 1'b1;
        step(3);
        chk(srst_n, 1'b0);
        step(1);
        chk(porp, 1'b0);
        chk(srst_n, 1'b0);
        wait_rel(1);
        step(4);
        chk(flag, 1'b0);
    endtask : t_por
    // software write, then a watchdog reset keeps the flag
    task t_flag;
        @(posedge clk_i) {fwr, fwd} <= 2'b11;
        @(posedge clk_i) fwr <= 1'b0;
        #1;
        chk(flag, 1'b1);
        @(posedge clk_i) wd <= 1'b1;
        step(1);
        chk(srst_n, 1'b0);
        chk(flag, 1'b1);
        @(posedge clk_i) wd <= 1'b0;
        wait_rel(3);
    endtask : t_flag
    // short low pulse is ignored
    task t_glitch;
        @(posedge clk_i) press <= 1'b1;
        repeat (48) begin
            step(1);
            chk(srst_n, 1'b1);
        end
        @(posedge clk_i) press <= 1'b0;
        step(3);
        chk(srst_n, 1'b1);
    endtask : t_glitch
    // long press resets, pin never driven, flag kept
    task t_pin;
        @(posedge clk_i) press <= 1'b1;
        step(56);
        chk(srst_n, 1'b0);
        chk(pad_oe, 1'b0);
        chk(pad_o, 1'b0);
        chk(flag, 1'b1);
        @(posedge clk_i) press <= 1'b0;
        wait_rel(4);
        chk(pdata, 1'b0);
    endtask : t_pin
    // disabled pin acts as a digital input
    task t_gpio;
        @(posedge clk_i) {cfg, press} <= 2'b01;
        step(60);
        chk(srst_n, 1'b1);
        chk(pdata, 1'b0);
        @(posedge clk_i) press <= 1'b0;
        step(2);
        chk(pdata, 1'b1);
        @(posedge clk_i) cfg <= 1'b1;
        step(2);
    endtask : t_gpio
    // verdict and end of run
    task test_done;
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // main sequence, second power-on at the end
    initial begin
        t_por();
        t_flag();
        t_glitch();
        t_pin();
        t_gpio();
        t_por();
        test_done();
    end
    // hang guard, several times the expected run
    initial begin
        repeat (1000) @(posedge clk_i);
        num_errors++;
        test_done();
    end
endmodule : external_and_power_on_reset_bench
`default_nettype wire

// File: verilog/epr_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
// carrier between the top and the glitch filter
interface epr_filt_if;
    logic pin_low; // pin seen low this cycle
    logic enable; // pin configured for reset use
    logic filt_low; // low has lasted long enough
    modport filt (input pin_low, input enable, output filt_low);
    modport user (output pin_low, output enable, input filt_low);
endinterface : epr_filt_if
`default_nettype wire

// File: verilog/epr_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "epr_params.svh"
module epr_glitch_filter (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // filter carrier
    epr_filt_if.filt fl
);
    // filter state and low-time counter
    epr_pkg::epr_filt_state_t state_q, state_d;
    logic [`EPR_FILT_CNT_W-1:0] cnt_q, cnt_d;
    // low seen while enabled
    wire logic low_en = fl.pin_low & fl.enable;
    // counter reached the least low time
    wire logic cnt_done = (cnt_q == `EPR_FILT_CNT_W'(`EPR_FILT_CYC - 1));

    // next state: any high or disable drops back to idle
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            epr_pkg::EPR_FILT_IDLE: begin
                cnt_d = '0;
                if (low_en) begin
                    state_d = epr_pkg::EPR_FILT_COUNT;
                end
            end
            epr_pkg::EPR_FILT_COUNT: begin
                if (!low_en) begin
                    // short pulse discarded
                    state_d = epr_pkg::EPR_FILT_IDLE;
                    cnt_d = '0;
                end else if (cnt_done) begin
                    state_d = epr_pkg::EPR_FILT_LOW;
                end else begin
                    cnt_d = cnt_q + `EPR_FILT_CNT_W'(1);
                end
            end
            default: begin
                // stays low while pin held low
                if (!low_en) begin
                    state_d = epr_pkg::EPR_FILT_IDLE;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= epr_pkg::EPR_FILT_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // filtered low only once held long enough
    assign fl.filt_low = (state_q == epr_pkg::EPR_FILT_LOW);

    // a filtered low needs a low seen while enabled exactly the least low time in cycles before it
    glitch_reject_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(fl.filt_low) |-> $past(low_en, `EPR_FILT_CYC))
        else $error("filtered low without a long enough low");
    // a disabled pin never yields a filtered low
    disable_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !fl.enable |=> !fl.filt_low)
        else $error("filtered low while pin disabled");
endmodule : epr_glitch_filter
`default_nettype wire

// File: verilog/epr_params.svh
`ifndef EPR_PARAMS_SVH
`define EPR_PARAMS_SVH
// clock period in ns (25 MHz)
`define EPR_CLK_NS 40
// least low time on the pin that counts as a reset, in ns
`define EPR_FILT_NS 2000
// least low time in cycles, rounded up
`define EPR_FILT_CYC ((`EPR_FILT_NS + `EPR_CLK_NS - 1) / `EPR_CLK_NS)
// width of the glitch filter counter
`define EPR_FILT_CNT_W 8
// power-on pulse length after supply good, in ns
`define EPR_POR_NS 160
// power-on pulse length in cycles, rounded up
`define EPR_POR_CYC ((`EPR_POR_NS + `EPR_CLK_NS - 1) / `EPR_CLK_NS)
// width of the power-on pulse counter
`define EPR_POR_CNT_W 4
// power-on flag value forced by a power-on reset
`define EPR_POR_FLAG_RST 1'b0
`endif

// File: verilog/epr_pkg.sv
`default_nettype none
package epr_pkg;
    // glitch filter states
    typedef enum logic [1:0] {
        EPR_FILT_IDLE,
        EPR_FILT_COUNT,
        EPR_FILT_LOW
    } epr_filt_state_t;
endpackage : epr_pkg
`default_nettype wire

// File: verilog/epr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "epr_params.svh"
// Notes on behaviour
// - low enabled pin holds device in reset
// - short low pulses on pin are filtered
// - pin is never driven by internal resets
// - config bit disables pin reset function
// - disabled pin reads as a digital input
// - supply rise gives a power-on reset pulse
// - power-on flag cleared by power-on, kept through watchdog and pin resets
// - only software may set the flag
module epr_top (
    // clock and power-on reset (low while supply below threshold)
    input wire logic clk_i,
    input wire logic arst_n_i,
    // external reset pin, two-way pad signals
    input wire logic external_reset_pin_i,
    output logic external_reset_pin_o,
    output logic external_reset_pin_oe_o,
    // configuration
    input wire logic ext_reset_pin_enable_cfg_i,
    // other internal reset source
    input wire logic watchdog_timer_rst_i,
    // power-on flag of the reset control register
    input wire logic por_flag_wr_i,
    input wire logic por_flag_wdata_i,
    output logic por_flag_o,
    // pin as digital input
    output logic pin_data_o,
    // combined reset to the device and power-on pulse
    output logic sys_rst_n_o,
    output logic por_pulse_o
);
    // filter carrier
    epr_filt_if fl ();
    // power-on pulse counter
    logic [`EPR_POR_CNT_W-1:0] por_cnt_q;
    // power-on flag, combined reset, pin data
    logic por_flag_q;
    logic sys_rst_q;
    logic pin_data_q;

    // pin low is an active reset level
    assign fl.pin_low = ~external_reset_pin_i;
    assign fl.enable = ext_reset_pin_enable_cfg_i;

    // filter instance
    epr_glitch_filter u_filt (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .fl(fl)
    );

    // power-on pulse still running
    wire logic por_active = (por_cnt_q != `EPR_POR_CNT_W'(`EPR_POR_CYC));
    // any enabled source active
    wire logic src_active = por_active | watchdog_timer_rst_i
        | (fl.filt_low & ext_reset_pin_enable_cfg_i);
    // flag next value: only a write changes it
    wire logic por_flag_d = por_flag_wr_i ? por_flag_wdata_i : por_flag_q;

    // power-on pulse counts from supply good
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            por_cnt_q <= '0;
        end else if (por_active) begin
            por_cnt_q <= por_cnt_q + `EPR_POR_CNT_W'(1);
        end
    end

    // power-on flag: cleared by power-on or by a software write of 0
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            por_flag_q <= `EPR_POR_FLAG_RST;
        end else begin
            por_flag_q <= por_flag_d;
        end
    end

    // combined reset: async assert on power-on, clocked assert from other sources, clocked release
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sys_rst_q <= 1'b1;
        end else begin
            sys_rst_q <= src_active;
        end
    end

    // pin level for software, only when not a reset pin
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_data_q <= 1'b0;
        end else begin
            pin_data_q <= ~ext_reset_pin_enable_cfg_i & external_reset_pin_i;
        end
    end

    // outputs; pad is input only
    assign external_reset_pin_o = 1'b0;
    assign external_reset_pin_oe_o = 1'b0;
    assign por_flag_o = por_flag_q;
    assign pin_data_o = pin_data_q;
    assign sys_rst_n_o = ~sys_rst_q;
    assign por_pulse_o = por_active;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    pin_never_driven_a: assert property (!external_reset_pin_oe_o)
        else $error("reset pin driven");
    ext_rst_hold_a: assert property (fl.filt_low && ext_reset_pin_enable_cfg_i
        |=> sys_rst_q)
        else $error("enabled pin low without reset");
    pin_input_a: assert property (!ext_reset_pin_enable_cfg_i
        |=> pin_data_o == $past(external_reset_pin_i))
        else $error("pin level not readable when disabled");
    por_pulse_a: assert property (por_active |=> sys_rst_q)
        else $error("power-on pulse without reset");
    flag_keep_a: assert property (!por_flag_wr_i |=> $stable(por_flag_o))
        else $error("flag changed without write");
    flag_set_sw_a: assert property ($rose(por_flag_o)
        |-> $past(por_flag_wr_i) && $past(por_flag_wdata_i))
        else $error("flag set by hardware");
    sync_release_a: assert property (sys_rst_q && !src_active |=> !sys_rst_n_o == 1'b0)
        else $error("reset not released");
    wdt_rst_a: assert property (watchdog_timer_rst_i
        |=> sys_rst_q ##0 ($stable(por_flag_o) || $past(por_flag_wr_i)))
        else $error("watchdog reset disturbed flag or failed");

    ext_rst_c: cover property (fl.filt_low ##1 !fl.filt_low);
    wdt_rst_c: cover property (!sys_rst_q ##1 watchdog_timer_rst_i);
    flag_set_c: cover property ($rose(por_flag_o));
    pin_gpio_c: cover property (!ext_reset_pin_enable_cfg_i && !external_reset_pin_i [*3]);
endmodule : epr_top
`default_nettype wire
